// *** hdl/bioalt_pkg.sv ***
package bioalt_pkg;

  // ---------------------------------------------------------------
  // port geometry and data-space map
  // ---------------------------------------------------------------
  localparam int unsigned WIDTH = 8;

  // register selector within one port
  localparam logic [1:0] SEL_DATA   = 2'h0;
  localparam logic [1:0] SEL_DIR    = 2'h1;
  localparam logic [1:0] SEL_OPTION = 2'h2;

  // port selector
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;

  // reset value of every port register
  localparam logic [7:0] REG_RESET = 8'h00;

  // alternate function pin positions
  localparam int unsigned TIMER1_BIT   = 1;  // port c
  localparam int unsigned SDI_BIT      = 2;  // port c
  localparam int unsigned SDO_BIT      = 3;  // port c
  localparam int unsigned SCK_BIT      = 4;  // port c
  localparam int unsigned AR_IN_BIT    = 6;  // port b
  localparam int unsigned AR_OUT_BIT   = 7;  // port b

  // miscellaneous register: spi data out enable bit
  localparam logic [7:0] MISC_ADDR      = 8'hdd;
  localparam int unsigned MISC_SDO_BIT  = 0;

  // interrupt trigger choice per port
  typedef enum logic [1:0] {
    BIOALT_TRIG_FALL,
    BIOALT_TRIG_RISE,
    BIOALT_TRIG_LOW
  } bioalt_trig_t;

  // per-line decoded configuration
  typedef struct packed {
    logic out_en;     // drives the pin
    logic push_pull;  // drives high as well as low
    logic pull_up;    // weak pull-up on
    logic irq_en;     // routed to interrupt system
    logic analog;     // routed to adc multiplexer
  } bioalt_cfg_t;

  // data-space access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] port;
    logic [1:0] sel;
    logic [7:0] wdata;
  } bioalt_acc_t;

  // on-chip peripheral hooks
  typedef struct packed {
    logic timer1_output_select;
    logic timer1_out;
    logic pwm_output_enable;
    logic autoreload_timer_out;
    logic spi_clock_output_select;
    logic spi_sck_out;
    logic serial_data_out;
  } bioalt_periph_t;

endpackage

// *** hdl/bioalt_port.sv ***
`timescale 1ns/100ps

// Contract
// R01: dir0 opt0 data0: pulled-up input, no interrupt
// R02: dir0 opt0 data1: high-impedance input only
// R03: dir0 opt1 data0: pulled-up input with interrupt
// R04: dir0 opt1 data1: analog input where supported
// R05: dir1 opt0: open-drain output of latch
// R06: dir1 opt1: push-pull output of latch
// R07: input lines read live pin level
// R08: writes store latch, outputs drive it
// R09: reset clears all port registers
// R10: three registers, bit n controls line n
// R11: detect falling, rising or low trigger
// R12: software selects one analog line only
// R13: timer pin feeds timer1 input normally
// R14: timer1 output select forces timer output
// R15: pwm enable forces autoreload output pin
// R16: software sets autoreload input as input
// R17: serial data in feeds spi when input
// R18: misc bit 0 forces push-pull data out
// R19: sck push-pull plus clock select drives clock
// R20: sck input plus select clear gives slave clock
// R21: select low leaves spi pins as plain io
// R22: synchronise pin inputs before use
module bioalt_port
  import bioalt_pkg::*;
#(
  parameter int unsigned PORTS      = 3,
  parameter logic [7:0]  ANALOG_MAP [3] = '{8'hff, 8'h00, 8'h1f}
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // core data-space access
  input  wire bioalt_acc_t           acc,
  input  wire logic [7:0]            misc_wdata,
  input  wire logic                  misc_wr,
  output logic [7:0]                 rdata,
  // trigger choice per port
  input  wire bioalt_trig_t          trig     [PORTS],
  // peripherals
  input  wire bioalt_periph_t        periph,
  // pins
  input  wire logic [WIDTH-1:0]      pin_in   [PORTS],
  output logic [WIDTH-1:0]           pin_out  [PORTS],
  output logic [WIDTH-1:0]           pin_oe   [PORTS],
  output logic [WIDTH-1:0]           pin_pu   [PORTS],
  output logic [WIDTH-1:0]           adc_sel  [PORTS],
  // to interrupt controller and peripherals
  output logic [PORTS-1:0]           port_irq,
  output logic                       timer1_in,
  output logic                       autoreload_timer_in,
  output logic                       spi_sdi,
  output logic                       spi_sck_in
);

  // ---------------------------------------------------------------
  // decode of one line from its three bits
  // ---------------------------------------------------------------
  function automatic bioalt_cfg_t decode(input logic d, input logic o, input logic l,
                                         input logic ana_ok);
    bioalt_cfg_t c;
    c = '0;
    if (d) begin
      c.out_en    = 1'b1;
      // R05 open drain
      // R06 push pull
      c.push_pull = o;
    end else begin
      // R01 pulled-up input
      // R02 high impedance
      // R03 interrupt input
      // R04 analog input
      c.pull_up = ~l;
      c.irq_en  = o & ~l;
      c.analog  = o & l & ana_ok;
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] port_data_latch_r [PORTS];
  logic [WIDTH-1:0] port_direction_r  [PORTS];
  logic [WIDTH-1:0] port_option_r     [PORTS];
  logic             misc_sdo_en_r;
  logic [WIDTH-1:0] sync1_r [PORTS];
  logic [WIDTH-1:0] sync2_r [PORTS];
  logic [WIDTH-1:0] sync3_r [PORTS];

  // R09 reset clear
  // R10 per line bits
  // R08 latch store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        port_data_latch_r[p] <= REG_RESET;
        port_direction_r[p]  <= REG_RESET;
        port_option_r[p]     <= REG_RESET;
      end
    end else if (acc.wr && acc.port < 2'(PORTS)) begin
      case (acc.sel)
        SEL_DATA:   port_data_latch_r[acc.port] <= acc.wdata;
        SEL_DIR:    port_direction_r[acc.port]  <= acc.wdata;
        SEL_OPTION: port_option_r[acc.port]     <= acc.wdata;
        default: ;
      endcase
    end
  end

  // R18 misc register bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      misc_sdo_en_r <= 1'b0;
    end else if (misc_wr) begin
      misc_sdo_en_r <= misc_wdata[MISC_SDO_BIT];
    end
  end

  // R22 two-stage synchroniser plus history, idle high like pulled-up pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        sync1_r[p] <= '1;
        sync2_r[p] <= '1;
        sync3_r[p] <= '1;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        sync1_r[p] <= pin_in[p];
        sync2_r[p] <= sync1_r[p];
        sync3_r[p] <= sync2_r[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive with alternate function overrides
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] out_nxt [PORTS];
  logic [WIDTH-1:0] oe_nxt  [PORTS];
  logic [WIDTH-1:0] pu_nxt  [PORTS];
  logic [WIDTH-1:0] ana_nxt [PORTS];
  logic [WIDTH-1:0] ien_nxt [PORTS];

  always_comb begin
    bioalt_cfg_t c;
    c = '0;
    for (int p = 0; p < PORTS; p++) begin
      for (int n = 0; n < WIDTH; n++) begin
        c = decode(port_direction_r[p][n], port_option_r[p][n],
                   port_data_latch_r[p][n], ANALOG_MAP[p][n]);
        // open drain pulls low only; push pull drives the latch
        out_nxt[p][n] = port_data_latch_r[p][n];
        oe_nxt[p][n]  = c.out_en & (c.push_pull | ~port_data_latch_r[p][n]);
        pu_nxt[p][n]  = c.pull_up;
        ana_nxt[p][n] = c.analog;
        ien_nxt[p][n] = c.irq_en;
      end
    end
    if (PORTS > 2) begin
      // R14 timer output override
      if (periph.timer1_output_select) begin
        out_nxt[PORT_C][TIMER1_BIT] = periph.timer1_out;
        oe_nxt[PORT_C][TIMER1_BIT]  = 1'b1;
        pu_nxt[PORT_C][TIMER1_BIT]  = 1'b0;
        ana_nxt[PORT_C][TIMER1_BIT] = 1'b0;
        ien_nxt[PORT_C][TIMER1_BIT] = 1'b0;
      end
      // R18 serial out override
      if (misc_sdo_en_r) begin
        out_nxt[PORT_C][SDO_BIT] = periph.serial_data_out;
        oe_nxt[PORT_C][SDO_BIT]  = 1'b1;
        pu_nxt[PORT_C][SDO_BIT]  = 1'b0;
        ana_nxt[PORT_C][SDO_BIT] = 1'b0;
        ien_nxt[PORT_C][SDO_BIT] = 1'b0;
      end
      // R19 master spi clock
      // R21 plain io while select low
      if (periph.spi_clock_output_select && port_direction_r[PORT_C][SCK_BIT]
          && port_option_r[PORT_C][SCK_BIT]) begin
        out_nxt[PORT_C][SCK_BIT] = periph.spi_sck_out;
        oe_nxt[PORT_C][SCK_BIT]  = 1'b1;
      end
    end
    // R15 pwm output override
    if (PORTS > 1 && periph.pwm_output_enable) begin
      out_nxt[PORT_B][AR_OUT_BIT] = periph.autoreload_timer_out;
      oe_nxt[PORT_B][AR_OUT_BIT]  = 1'b1;
      pu_nxt[PORT_B][AR_OUT_BIT]  = 1'b0;
      ana_nxt[PORT_B][AR_OUT_BIT] = 1'b0;
      ien_nxt[PORT_B][AR_OUT_BIT] = 1'b0;
    end
  end

  // registered pin outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        pin_out[p] <= '0;
        pin_oe[p]  <= '0;
        pin_pu[p]  <= '1;
        adc_sel[p] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        pin_out[p] <= out_nxt[p];
        pin_oe[p]  <= oe_nxt[p];
        pin_pu[p]  <= pu_nxt[p];
        adc_sel[p] <= ana_nxt[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt trigger detection
  // ---------------------------------------------------------------
  logic [PORTS-1:0] irq_nxt;

  // R11 trigger detect
  always_comb begin
    logic [WIDTH-1:0] hit;
    hit = '0;
    for (int p = 0; p < PORTS; p++) begin
      case (trig[p])
        BIOALT_TRIG_FALL: hit = sync3_r[p] & ~sync2_r[p];
        BIOALT_TRIG_RISE: hit = ~sync3_r[p] & sync2_r[p];
        BIOALT_TRIG_LOW:  hit = ~sync2_r[p];
        default:          hit = '0;
      endcase
      irq_nxt[p] = |(hit & ien_nxt[p]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_irq <= '0;
    end else begin
      port_irq <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // peripheral inputs and read path
  // ---------------------------------------------------------------
  // R13 timer input
  // R16 autoreload input
  // R17 serial data in
  // R20 slave clock in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer1_in           <= 1'b0;
      autoreload_timer_in <= 1'b0;
      spi_sdi             <= 1'b0;
      spi_sck_in          <= 1'b0;
    end else begin
      timer1_in           <= (PORTS > 2) ? sync2_r[PORT_C][TIMER1_BIT] : 1'b0;
      autoreload_timer_in <= (PORTS > 1) ? sync2_r[PORT_B][AR_IN_BIT] : 1'b0;
      spi_sdi             <= (PORTS > 2 && !port_direction_r[PORT_C][SDI_BIT])
                             ? sync2_r[PORT_C][SDI_BIT] : 1'b0;
      spi_sck_in          <= (PORTS > 2 && !port_direction_r[PORT_C][SCK_BIT]
                              && !periph.spi_clock_output_select)
                             ? sync2_r[PORT_C][SCK_BIT] : 1'b0;
    end
  end

  // R07 live pin read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (acc.rd && acc.port < 2'(PORTS)) begin
      case (acc.sel)
        SEL_DATA:   rdata <= (port_direction_r[acc.port] & port_data_latch_r[acc.port])
                             | (~port_direction_r[acc.port] & sync2_r[acc.port]);
        SEL_DIR:    rdata <= port_direction_r[acc.port];
        SEL_OPTION: rdata <= port_option_r[acc.port];
        default:    rdata <= '0;
      endcase
    end else if (acc.rd) begin
      rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // port a line 0 mode as direction, option, latch
  logic [2:0] a0_mode;
  assign a0_mode = {port_direction_r[PORT_A][0], port_option_r[PORT_A][0],
                    port_data_latch_r[PORT_A][0]};

  a_reset_pullups: assert property (@(posedge clk) // R09
    $rose(arst_n) |-> pin_pu[PORT_A] == '1)
    else $error("pull-ups not on after reset");
  a_write_stores: assert property (@(posedge clk) disable iff (!arst_n) // R08
    acc.wr && acc.port == PORT_A && acc.sel == SEL_DATA
    |=> port_data_latch_r[PORT_A] == $past(acc.wdata))
    else $error("data write not stored");
  a_pushpull_drive: assert property (@(posedge clk) disable iff (!arst_n) // R06
    a0_mode[2:1] == 2'b11
    |=> pin_oe[PORT_A][0] && pin_out[PORT_A][0] == $past(port_data_latch_r[PORT_A][0]))
    else $error("push-pull line not driven");
  a_opendrain_high: assert property (@(posedge clk) disable iff (!arst_n) // R05
    a0_mode == 3'b101 |=> !pin_oe[PORT_A][0])
    else $error("open-drain drives high");
  a_opendrain_low: assert property (@(posedge clk) disable iff (!arst_n) // R05
    a0_mode == 3'b100 |=> pin_oe[PORT_A][0] && !pin_out[PORT_A][0])
    else $error("open-drain does not pull low");
  a_hiz_input: assert property (@(posedge clk) disable iff (!arst_n) // R02
    a0_mode == 3'b001 |=> !pin_pu[PORT_A][0] && !pin_oe[PORT_A][0])
    else $error("high-impedance input not floating");
  a_pullup_input: assert property (@(posedge clk) disable iff (!arst_n) // R01
    a0_mode == 3'b000 |=> pin_pu[PORT_A][0] && !pin_oe[PORT_A][0] && !adc_sel[PORT_A][0])
    else $error("pulled-up input wrong");
  a_irq_input: assert property (@(posedge clk) disable iff (!arst_n) // R03
    a0_mode == 3'b010 |-> ien_nxt[PORT_A][0] ##1 (pin_pu[PORT_A][0] && !adc_sel[PORT_A][0]))
    else $error("interrupt input wrong");
  a_analog_sel: assert property (@(posedge clk) disable iff (!arst_n) // R04
    a0_mode == 3'b011 |=> adc_sel[PORT_A][0])
    else $error("analog line not routed");
  a_input_read: assert property (@(posedge clk) disable iff (!arst_n) // R07
    acc.rd && acc.port == PORT_A && acc.sel == SEL_DATA && port_direction_r[PORT_A] == '0
    |=> rdata == $past(sync2_r[PORT_A]))
    else $error("input read not from pin");
  a_low_irq: assert property (@(posedge clk) disable iff (!arst_n) // R11
    trig[PORT_B] == BIOALT_TRIG_LOW && ien_nxt[PORT_B][0] && !sync2_r[PORT_B][0]
    |=> port_irq[PORT_B])
    else $error("low level trigger missed");
  a_timer_override: assert property (@(posedge clk) disable iff (!arst_n) // R14
    periph.timer1_output_select |=> pin_oe[PORT_C][TIMER1_BIT]
      && pin_out[PORT_C][TIMER1_BIT] == $past(periph.timer1_out))
    else $error("timer output not forced");
  a_pwm_override: assert property (@(posedge clk) disable iff (!arst_n) // R15
    periph.pwm_output_enable |=> pin_oe[PORT_B][AR_OUT_BIT]
      && pin_out[PORT_B][AR_OUT_BIT] == $past(periph.autoreload_timer_out))
    else $error("pwm output not forced");
  a_sdo_override: assert property (@(posedge clk) disable iff (!arst_n) // R18
    misc_sdo_en_r |=> pin_oe[PORT_C][SDO_BIT]
      && pin_out[PORT_C][SDO_BIT] == $past(periph.serial_data_out))
    else $error("serial data out not forced");
  a_sck_master: assert property (@(posedge clk) disable iff (!arst_n) // R19
    periph.spi_clock_output_select && port_direction_r[PORT_C][SCK_BIT]
      && port_option_r[PORT_C][SCK_BIT]
    |=> pin_oe[PORT_C][SCK_BIT] && pin_out[PORT_C][SCK_BIT] == $past(periph.spi_sck_out))
    else $error("master clock not driven");
  a_sdi_feed: assert property (@(posedge clk) disable iff (!arst_n) // R17
    !port_direction_r[PORT_C][SDI_BIT] |=> spi_sdi == $past(sync2_r[PORT_C][SDI_BIT]))
    else $error("serial data in not fed");
  a_sck_slave: assert property (@(posedge clk) disable iff (!arst_n) // R20
    !port_direction_r[PORT_C][SCK_BIT] && !periph.spi_clock_output_select
    |=> spi_sck_in == $past(sync2_r[PORT_C][SCK_BIT]))
    else $error("slave clock not fed");

endmodule // bioalt_port

// *** testbench/bioalt_pins.sv ***
`timescale 1ns/100ps

// ---------------------------------------------
// board-side pin model
// ---------------------------------------------
module bioalt_pins
  import bioalt_pkg::*;
(
  // clock
  input  wire logic             clk,
  // device drive
  input  wire logic [WIDTH-1:0] pin_out [3],
  input  wire logic [WIDTH-1:0] pin_oe  [3],
  input  wire logic [WIDTH-1:0] pin_pu  [3],
  // board drive
  input  wire logic [WIDTH-1:0] ext_drv [3],
  input  wire logic [WIDTH-1:0] ext_val [3],
  output logic [WIDTH-1:0]      pin_in  [3]
);
  logic [WIDTH-1:0] flt_r = 8'h55;

  // an undriven line without pull-up flips every cycle
  always_ff @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  // wire level: device, else board, else pull-up, else floating
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pin_in[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_drv[p] & ext_val[p])
                | (~pin_oe[p] & ~ext_drv[p] & (pin_pu[p] | flt_r));
    end
  end
endmodule // bioalt_pins

// *** testbench/bioalt_port_tb.sv ***
`timescale 1ns/100ps

module bioalt_port_tb
  import bioalt_pkg::*;
;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic           clk         = 1'b0;
  logic           arst_n      = 1'b0;
  bioalt_acc_t    acc         = '0;
  logic [7:0]     misc_wdata  = 8'h00;
  logic           misc_wr     = 1'b0;
  bioalt_trig_t   trig [3]    = '{BIOALT_TRIG_FALL, BIOALT_TRIG_FALL, BIOALT_TRIG_FALL};
  bioalt_periph_t periph      = '0;
  logic [7:0]     ext_drv [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]     ext_val [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]     pin_in [3], pin_out [3], pin_oe [3], pin_pu [3], adc_sel [3];
  logic [7:0]     rdata, r, dir, opt, dat, an;
  logic [2:0]     port_irq;
  logic           timer1_in, autoreload_timer_in, spi_sdi, spi_sck_in;
  logic [1:0]     p;
  int             n_fail = 0, check_count = 0, cyc = 0, n;
  localparam logic [7:0] AMAP [3] = '{8'hff, 8'h00, 8'h1f};

  bioalt_port uut (.clk(clk), .arst_n(arst_n), .acc(acc), .misc_wdata(misc_wdata),
    .misc_wr(misc_wr), .rdata(rdata), .trig(trig), .periph(periph), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .adc_sel(adc_sel),
    .port_irq(port_irq), .timer1_in(timer1_in), .autoreload_timer_in(autoreload_timer_in),
    .spi_sdi(spi_sdi), .spi_sck_in(spi_sck_in));

  bioalt_pins pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      conclude();
    end
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] pt, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    acc = '{1'b1, 1'b0, pt, s, d};
    @(negedge clk);
    acc.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] pt, input logic [1:0] s, output logic [7:0] d);
    @(negedge clk);
    acc = '{1'b0, 1'b1, pt, s, 8'h00};
    @(negedge clk);
    acc.rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic misc(input logic [7:0] d);
    @(negedge clk);
    misc_wdata = d;
    misc_wr = 1'b1;
    @(negedge clk);
    misc_wr = 1'b0;
  endtask

  // count interrupt cycles after moving port b line 0
  task automatic cnt_irq(input logic v, output int k);
    ext_val[1][0] = v;
    k = 0;
    repeat (10) begin
      @(negedge clk);
      k += int'(port_irq[1] === 1'b1);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    r = 8'($urandom(32'h9922af61));
    repeat (16) @(negedge clk);
    chk(pin_oe[0] | pin_oe[1] | pin_oe[2], 8'h00, "reset oe");
    chk(pin_pu[0] & pin_pu[1] & pin_pu[2], 8'hff, "reset pull");
    arst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(2'(i / 3), 2'(i % 3), r);
      chk(r, (2'(i % 3) == SEL_DATA) ? 8'hff : REG_RESET, "reset reg");
    end
    $display("test reset done");

    // random line modes with corner patterns first
    for (int i = 0; i < 150; i++) begin
      p = 2'($urandom_range(2, 0));
      dir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      opt = (i == 0) ? 8'h00 : (i == 1) ? 8'h0f : 8'($urandom);
      dat = (i == 0) ? 8'h00 : (i == 1) ? 8'h31 : 8'($urandom);
      an = ~dir & opt & dat;
      dat = dat & ~(an & (an - 8'h01));
      an = ~dir & opt & dat;
      wr(p, SEL_DIR, dir);
      wr(p, SEL_OPTION, opt);
      wr(p, SEL_DATA, dat);
      ext_drv[p] = ~dir;
      ext_val[p] = 8'($urandom);
      repeat (4) @(negedge clk);
      chk(pin_oe[p], dir & (opt | ~dat), "oe");
      chk(pin_out[p] & dir & (opt | ~dat), dat & dir & (opt | ~dat), "out");
      chk(pin_pu[p] & ~dir, ~dat & ~dir, "pull");
      chk(adc_sel[p], an & AMAP[p], "adc");
      rd(p, SEL_DATA, r);
      chk(r, (dir & dat) | (~dir & ext_val[p]), "data read");
      rd(p, SEL_DIR, r);
      chk(r, dir, "dir read");
      rd(p, SEL_OPTION, r);
      chk(r, opt, "opt read");
    end
    $display("test modes done");

    // interrupt triggers on port b line 0
    wr(PORT_B, SEL_DIR, 8'h00);
    wr(PORT_B, SEL_OPTION, 8'h01);
    wr(PORT_B, SEL_DATA, 8'h00);
    ext_drv[1] = 8'hff;
    for (int t = 0; t < 3; t++) begin
      trig[1] = bioalt_trig_t'(t);
      ext_val[1] = 8'hff;
      repeat (6) @(negedge clk);
      cnt_irq(1'b0, n);
      chk((t == 2) ? 8'(n > 4) : 8'(n), (t == 1) ? 8'h00 : 8'h01, "irq fall");
      cnt_irq(1'b1, n);
      if (t != 2) chk(8'(n), (t == 1) ? 8'h01 : 8'h00, "irq rise");
    end
    wr(PORT_B, SEL_OPTION, 8'h00);
    cnt_irq(1'b0, n);
    chk(8'(n), 8'h00, "irq off");
    $display("test irq done");

    // alternate functions
    for (int v = 0; v < 2; v++) begin
      wr(PORT_C, SEL_DIR, 8'h00);
      wr(PORT_C, SEL_OPTION, 8'h00);
      wr(PORT_C, SEL_DATA, 8'h00);
      wr(PORT_B, SEL_DIR, 8'h00);
      periph = '0;
      r = 8'($urandom);
      ext_drv[2] = 8'hff;
      ext_drv[1] = 8'hff;
      ext_val[2] = r;
      ext_val[1] = ~r;
      repeat (4) @(negedge clk);
      chk(8'(timer1_in), 8'(r[1]), "timer in");
      chk(8'(autoreload_timer_in), {7'h00, ~r[6]}, "ar in");
      chk(8'(spi_sdi), 8'(r[2]), "sdi");
      chk(8'(spi_sck_in), 8'(r[4]), "sck in");
      rd(PORT_C, SEL_DATA, dat);
      chk(dat, r, "spi pins plain");
      periph = '{1'b1, v[0], 1'b1, ~v[0], 1'b0, 1'b0, v[0]};
      ext_drv[2] = 8'he5;
      ext_drv[1] = 8'h7f;
      misc(8'h01);
      repeat (4) @(negedge clk);
      chk({6'h00, pin_oe[2][TIMER1_BIT], pin_out[2][TIMER1_BIT]}, 8'h02 | 8'(v), "t1");
      chk({6'h00, pin_oe[1][AR_OUT_BIT], pin_out[1][AR_OUT_BIT]}, 8'h03 ^ 8'(v), "pwm");
      chk({6'h00, pin_oe[2][SDO_BIT], pin_out[2][SDO_BIT]}, 8'h02 | 8'(v), "sdo");
      periph.spi_clock_output_select = 1'b1;
      periph.spi_sck_out = v[0];
      wr(PORT_C, SEL_DIR, 8'h10);
      wr(PORT_C, SEL_OPTION, 8'h10);
      repeat (4) @(negedge clk);
      chk({6'h00, pin_oe[2][SCK_BIT], pin_out[2][SCK_BIT]}, 8'h02 | 8'(v), "sck");
      chk(8'(spi_sdi), 8'(r[2]), "sdi master");
      misc(8'h00);
    end
    $display("test alternate done");

    // reset again in mid run: registers and drives clear
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk(pin_oe[0] | pin_oe[1] | pin_oe[2], 8'h00, "mid reset oe");
    arst_n = 1'b1;
    rd(PORT_C, SEL_OPTION, r);
    chk(r, REG_RESET, "mid reset opt");
    $display("test mid reset done");
    conclude();
  end
endmodule // bioalt_port_tb
